// ### src/auto_rate_select_control.sv
// rate selection control: scan sequencer, harmonic lock detector, index latch
// ------------------------------------------------------------
// Overview of operation
// - in auto mode, scan request steps index each scan period
// - request drops once locked, index held
// - request needs carrier and unlock or harmonic
// - count bit changes over three clock periods
// - harmonic flag clear at rate above eighth
// - harmonic flag rises after at least 2 us
// - sparse interval shorter than period never steps
// - auto mode drives index onto rate bus
// - manual mode: strobe high loads bus, low holds; auto mode ignores strobe
// - manual mode releases rate bus drivers
// - manual mode request flags mismatched rate
// ------------------------------------------------------------
`timescale 1ns/1ps
module auto_rate_select_control
#(
    parameter int unsigned SCAN_PERIOD = rate_sel_pkg::SCAN_PERIOD_DEF,
    parameter int unsigned HWIN        = rate_sel_pkg::HWIN_DEF,
    parameter int unsigned HARMONIC_LOCK_FLAG_CYC   = rate_sel_pkg::HARMONIC_LOCK_FLAG_DELAY_CYC
)
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst_b,
    input  wire rate_sel_pkg::lock_in_t lock_in,
    input  wire logic                   data_in,
    input  wire logic                   rate_write_strobe,
    input  wire logic [1:0]             rate_index_in,
    output rate_sel_pkg::rate_bus_t     rate_bus,
    output logic [1:0]                  rate_index,
    output logic                        scan_request,
    output logic                        harmonic_lock_flag
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    wire        rst_n = rst_sync_q[1];

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b) rst_sync_q <= 2'h0;
        else        rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    // ------------------------------------------------------------
    // harmonic lock detector
    // ------------------------------------------------------------
    // data_in is sampled once per recovered clock period (clk_sys here)
    logic [rate_sel_pkg::SR_W-1:0] hist_q;
    logic [15:0]                   win_q;
    logic [15:0]                   hit_q;
    logic [31:0]                   hcnt_q;
    logic                          harm_cond_q;
    logic                          harmonic_lock_flag_q;

    // a change in each of three consecutive periods: 1010-type pattern
    wire tri_change = (hist_q[2] ^ hist_q[1]) & (hist_q[1] ^ hist_q[0])
                    & (hist_q[0] ^ data_in);
    wire win_end    = (win_q == 16'(HWIN - 1));
    // fewer than one eighth of periods carried the event
    wire rate_low   = ({hit_q, 3'h0} < {3'h0, 16'(HWIN)});
    wire hdly_done  = (hcnt_q >= HARMONIC_LOCK_FLAG_CYC - 1);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hist_q      <= '0;
            win_q       <= 16'h0;
            hit_q       <= 16'h0;
            harm_cond_q <= 1'b0;
        end
        else
        begin
            hist_q      <= {hist_q[1:0], data_in};
            win_q       <= win_end ? 16'h0 : win_q + 16'h1;
            hit_q       <= win_end ? 16'h0 : hit_q + {15'h0, tri_change};
            harm_cond_q <= win_end ? rate_low : harm_cond_q;
        end
    end

    // flag rises only after the condition holds for the full delay
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hcnt_q               <= 32'h0;
            harmonic_lock_flag_q <= 1'b0;
        end
        else if (!harm_cond_q)
        begin
            hcnt_q               <= 32'h0;
            harmonic_lock_flag_q <= 1'b0;
        end
        else
        begin
            hcnt_q               <= hdly_done ? hcnt_q : hcnt_q + 32'h1;
            harmonic_lock_flag_q <= hdly_done;
        end
    end

    // ------------------------------------------------------------
    // index arithmetic
    // ------------------------------------------------------------
    // two bits wrap from three to zero on their own, no compare needed
    function automatic logic [1:0] next_idx(input logic [1:0] cur);
        next_idx = cur + rate_sel_pkg::IDX_STEP;
    endfunction

    // check counters saturate so a long run cannot roll over and fire falsely
    function automatic logic [31:0] sat_inc(input logic [31:0] cur);
        sat_inc = (cur == 32'hffff_ffff) ? cur : cur + 32'h1;
    endfunction

    // ------------------------------------------------------------
    // scan request and sequencer
    // ------------------------------------------------------------
    rate_sel_pkg::scan_state_t state_q;
    logic [31:0]               scnt_q;
    logic [1:0]                idx_q;

    wire req_c      = lock_in.carrier_detect
                    & (lock_in.freq_unlock_flag | harmonic_lock_flag_q);
    wire auto_mode  = !lock_in.manual_rate_mode;
    // whole period of continuous request needed; shorter bursts restart it
    wire period_end = (scnt_q == SCAN_PERIOD - 1);
    wire step       = auto_mode && (state_q == rate_sel_pkg::ST_SCAN)
                    && req_c && period_end;
    // strobe comes from outside; in auto mode it is our request fed back
    wire load       = rate_write_strobe && lock_in.manual_rate_mode;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= rate_sel_pkg::ST_HOLD;
            scnt_q  <= 32'h0;
        end
        else
        begin
            state_q <= (req_c && auto_mode) ? rate_sel_pkg::ST_SCAN
                                            : rate_sel_pkg::ST_HOLD;
            scnt_q  <= (!req_c || !auto_mode || period_end) ? 32'h0
                                                            : scnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)     idx_q <= rate_sel_pkg::IDX_RST;
        else if (load)  idx_q <= rate_index_in;
        else if (step)  idx_q <= next_idx(idx_q);
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign scan_request       = req_c;
    assign harmonic_lock_flag = harmonic_lock_flag_q;
    assign rate_index         = idx_q;
    assign rate_bus.o         = idx_q;
    assign rate_bus.oe        = auto_mode ? 2'h3 : 2'h0;

    // ------------------------------------------------------------
    // check helpers
    // ------------------------------------------------------------
    // counted apart from the sequencer so the checks do not reuse its counters
    logic [31:0] req_run_q;
    logic [31:0] cond_run_q;

    wire req_live = req_c && auto_mode;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)         req_run_q <= 32'h0;
        else if (!req_live) req_run_q <= 32'h0;
        else                req_run_q <= sat_inc(req_run_q);
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)            cond_run_q <= 32'h0;
        else if (!harm_cond_q) cond_run_q <= 32'h0;
        else                   cond_run_q <= sat_inc(cond_run_q);
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_req_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        scan_request == (lock_in.carrier_detect
            && (lock_in.freq_unlock_flag || harmonic_lock_flag)))
        else $error("scan request gating wrong");
    a_idx_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!scan_request && !load) |=> $stable(rate_index))
        else $error("index moved without request");
    a_idx_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (step && !load && rate_index == 2'h3) |=> rate_index == 2'h0)
        else $error("index did not wrap");
    a_idx_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (step && !load) |=> rate_index == $past(rate_index) + 2'h1)
        else $error("index did not step");
    a_man_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
        load |=> rate_index == $past(rate_index_in))
        else $error("manual load missed");
    a_bus_tri: assert property (@(posedge clk_sys) disable iff (!rst_n)
        lock_in.manual_rate_mode |-> rate_bus.oe == 2'h0)
        else $error("bus driven in manual mode");
    a_bus_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !lock_in.manual_rate_mode |-> (rate_bus.oe == 2'h3
            && rate_bus.o == rate_index))
        else $error("bus not showing index");
    a_harmonic_lock_flag_dly: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(harmonic_lock_flag) |-> hcnt_q >= HARMONIC_LOCK_FLAG_CYC - 1)
        else $error("harmonic flag too early");
    a_sparse_ok: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (step) |-> scnt_q == SCAN_PERIOD - 1)
        else $error("step before full period");
    a_harm_clr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !harm_cond_q |=> !harmonic_lock_flag)
        else $error("harmonic flag not cleared");

    // ------------------------------------------------------------
    // checks: request and index
    // ------------------------------------------------------------
    a_step_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
        step |-> req_run_q >= SCAN_PERIOD - 1)
        else $error("step after short request");
    a_man_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (lock_in.manual_rate_mode && !load) |=> $stable(rate_index))
        else $error("index moved in manual mode");
    a_auto_strobe: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (auto_mode && !step) |=> $stable(rate_index))
        else $error("strobe loaded in auto mode");
    a_step_auto: assert property (@(posedge clk_sys) disable iff (!rst_n)
        step |-> !lock_in.manual_rate_mode)
        else $error("step in manual mode");
    a_req_carrier: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !lock_in.carrier_detect |-> !scan_request)
        else $error("request without carrier");
    a_req_unlock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (lock_in.carrier_detect && lock_in.freq_unlock_flag) |-> scan_request)
        else $error("unlock gave no request");
    a_req_harm: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (lock_in.carrier_detect && harmonic_lock_flag) |-> scan_request)
        else $error("harmonic gave no request");
    a_scan_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == rate_sel_pkg::ST_SCAN) |-> $past(req_c && auto_mode))
        else $error("scan state without request");
    a_state_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !req_live |=> state_q == rate_sel_pkg::ST_HOLD)
        else $error("scan state held without request");
    a_scnt_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
        scnt_q < SCAN_PERIOD)
        else $error("scan count out of range");

    // ------------------------------------------------------------
    // checks: harmonic detector
    // ------------------------------------------------------------
    a_harmonic_lock_flag_min: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(harmonic_lock_flag) |-> cond_run_q >= HARMONIC_LOCK_FLAG_CYC)
        else $error("harmonic flag before delay");
    a_flag_cond: assert property (@(posedge clk_sys) disable iff (!rst_n)
        harmonic_lock_flag |-> $past(harm_cond_q))
        else $error("harmonic flag without condition");
    a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (harmonic_lock_flag && harm_cond_q) |=> harmonic_lock_flag)
        else $error("harmonic flag dropped early");
    a_hcnt_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !harm_cond_q |=> hcnt_q == 32'h0)
        else $error("delay count not cleared");
    a_win_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
        win_q < 16'(HWIN))
        else $error("window count out of range");
    a_win_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        win_end |=> win_q == 16'h0)
        else $error("window did not restart");
    a_hit_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
        hit_q <= win_q)
        else $error("more hits than periods");
    a_cond_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !win_end |=> $stable(harm_cond_q))
        else $error("condition moved inside window");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------

    c_step:   cover property (@(posedge clk_sys) disable iff (!rst_n) step);
    c_wrap:   cover property (@(posedge clk_sys) disable iff (!rst_n)
        step && rate_index == 2'h3);
    c_harmonic_lock_flag:  cover property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(harmonic_lock_flag));
    c_load:   cover property (@(posedge clk_sys) disable iff (!rst_n) load);
    c_hclear: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(harmonic_lock_flag));
endmodule

// ### src/rate_sel_pkg.sv
// shared constants and types for the rate selection control
package rate_sel_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS    = 10000;
    localparam int unsigned HARMONIC_LOCK_FLAG_DELAY_PS   = 2000000;
    // least time rounds up
    localparam int unsigned HARMONIC_LOCK_FLAG_DELAY_CYC  =
        (HARMONIC_LOCK_FLAG_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SCAN_PERIOD_DEF  = 100000;
    localparam int unsigned HWIN_DEF         = 64;
    // ------------------------------------------------------------
    // widths and values
    // ------------------------------------------------------------
    localparam int unsigned IDX_W     = 2;
    localparam logic [1:0]  IDX_RST   = 2'h0;
    localparam logic [1:0]  IDX_STEP  = 2'h1;
    localparam int unsigned SR_W      = 3;

    typedef enum logic [1:0]
    {
        ST_HOLD = 2'b00,
        ST_SCAN = 2'b01
    } scan_state_t;

    typedef struct packed
    {
        logic       carrier_detect;
        logic       freq_unlock_flag;
        logic       manual_rate_mode;
    } lock_in_t;

    typedef struct packed
    {
        logic [1:0] o;
        logic [1:0] oe;
    } rate_bus_t;
endpackage

// ### sim/rate_ctrl_model.sv
// behavioural system controller on the rate pins and write strobe
`timescale 1ns/1ps
module rate_ctrl_model
(
    input  wire logic                    manual_rate_mode,
    input  wire logic                    scan_request,
    input  wire rate_sel_pkg::rate_bus_t rate_bus,
    input  wire logic [1:0]              host_idx,
    input  wire logic                    host_wr,
    output logic                         rate_write_strobe,
    output logic [1:0]                   rate_index_in
);
    // auto mode closes the request loop; the rc delay is not modelled
    assign rate_write_strobe = manual_rate_mode ? host_wr : scan_request;
    // nobody drives in auto with buffers off: show the inverse, not the old value
    assign rate_index_in = (rate_bus.oe == 2'h3) ? rate_bus.o
                         : (manual_rate_mode ? host_idx : ~rate_bus.o);
endmodule

// ### sim/tb.sv
// self-checking bench for the rate selection control
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
    localparam int unsigned SP = 20;
    localparam int unsigned HW = 16;
    localparam int unsigned HL = 4;
    logic                    clk_sys;
    logic                    rst_b;
    logic                    data_in;
    logic                    toggle;
    logic                    host_wr;
    logic                    strobe;
    logic [1:0]              host_idx;
    logic [1:0]              bus_in;
    logic [1:0]              rate_index;
    logic                    scan_request;
    logic                    harmonic_lock_flag;
    rate_sel_pkg::lock_in_t  lock_in;
    rate_sel_pkg::rate_bus_t rate_bus;
    int                      errors;
    int                      num_checks;

    auto_rate_select_control #(.SCAN_PERIOD(SP), .HWIN(HW), .HARMONIC_LOCK_FLAG_CYC(HL)) i_dut
    (
        .clk_sys(clk_sys), .rst_b(rst_b), .lock_in(lock_in), .data_in(data_in),
        .rate_write_strobe(strobe), .rate_index_in(bus_in), .rate_bus(rate_bus),
        .rate_index(rate_index), .scan_request(scan_request),
        .harmonic_lock_flag(harmonic_lock_flag)
    );
    rate_ctrl_model i_host
    (
        .manual_rate_mode(lock_in.manual_rate_mode), .scan_request(scan_request),
        .rate_bus(rate_bus), .host_idx(host_idx), .host_wr(host_wr),
        .rate_write_strobe(strobe), .rate_index_in(bus_in)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // dense data keeps the harmonic detector quiet; constant data mimics a harmonic
    always @(posedge clk_sys) data_in <= toggle ? ~data_in : data_in;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic load(input logic [1:0] v);
        host_idx <= v;
        host_wr  <= 1'b1;
        cyc(1);
        host_wr  <= 1'b0;
        #1;
    endtask
    task automatic test_done();
        if (errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        rst_b = 1'b0; lock_in = '0; toggle = 1'b1; data_in = 1'b0;
        host_idx = 2'h0; host_wr = 1'b0; errors = 0; num_checks = 0;
        cyc(10); rst_b <= 1'b1; #1;
        `CHK(rate_index, 2'h0) `CHK(harmonic_lock_flag, 1'b0)
        cyc(3); lock_in.manual_rate_mode <= 1'b1;
        cyc(1);
        for (int i = 0; i < 4; i++)
        begin
            load(2'(i)); `CHK(rate_index, 2'(i))
        end
        host_idx <= 2'h1; cyc(3); #1;
        `CHK(rate_index, 2'h3)
        `CHK(rate_bus.oe, 2'h0)
        lock_in.carrier_detect <= 1'b1; lock_in.freq_unlock_flag <= 1'b1; cyc(1); #1;
        `CHK(scan_request, 1'b1)
        cyc(SP + 5); #1; `CHK(rate_index, 2'h3)
        lock_in.carrier_detect <= 1'b0; cyc(1); #1; `CHK(scan_request, 1'b0)
        lock_in.manual_rate_mode <= 1'b0; lock_in.carrier_detect <= 1'b1; cyc(1); #1;
        `CHK(rate_bus.oe, 2'h3)
        cyc(SP - 2); #1; `CHK(rate_index, 2'h3)
        cyc(4); #1; `CHK(rate_index, 2'h0)
        `CHK(rate_bus.o, 2'h0)
        // requests shorter than one scan period must never step the index
        for (int i = 0; i < 3; i++)
        begin
            lock_in.freq_unlock_flag <= 1'b0; cyc(2);
            lock_in.freq_unlock_flag <= 1'b1; cyc(SP - 2);
        end
        lock_in.freq_unlock_flag <= 1'b0; cyc(3 * SP); #1;
        `CHK(rate_index, 2'h0)
        `CHK(scan_request, 1'b0)
        toggle <= 1'b0; cyc(HL); #1; `CHK(harmonic_lock_flag, 1'b0)
        cyc(2 * HW + HL + 2); #1; `CHK(harmonic_lock_flag, 1'b1)
        `CHK(scan_request, 1'b1)
        toggle <= 1'b1; cyc(2 * HW + 2); #1; `CHK(harmonic_lock_flag, 1'b0)
        // fixed rate: strobe held high, index follows the tied bus lines
        lock_in.manual_rate_mode <= 1'b1; host_wr <= 1'b1; host_idx <= 2'h2; cyc(2); #1;
        `CHK(rate_index, 2'h2)
        host_idx <= 2'h1; cyc(2); #1; `CHK(rate_index, 2'h1)
        `CHK(rate_bus.oe, 2'h0)
        test_done();
    end
    initial
    begin
        cyc(5000);
        errors++;
        test_done();
    end
endmodule
